// ### ppa_pkg.sv
// Purpose: Shared constants and carrier types of the pulse positioning axis
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register bus
// Notes:   Speeds are phase-accumulator increments, f = speed * 100 MHz / 2**32
package ppa_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int         ADDR_W         = 8;
  localparam logic [7:0] REG_CMD        = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_TARGET     = 8'h08;
  localparam logic [7:0] REG_RUN_SPEED  = 8'h0c;
  localparam logic [7:0] REG_HOME_SPEED = 8'h10;
  localparam logic [7:0] REG_CREEP      = 8'h14;
  localparam logic [7:0] REG_RAMP_STEP  = 8'h18;
  localparam logic [7:0] REG_POSITION   = 8'h1c;

  // Status bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_FAULT   = 3;
  localparam int ST_POS_OK  = 4;
  localparam int ST_DIR     = 5;
  localparam int ST_NEAR    = 6;
  localparam int ST_ZERO    = 7;
  localparam int ST_FWD_LIM = 8;
  localparam int ST_BWD_LIM = 9;
  localparam int ST_ENABLE  = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS       = 10;
  localparam int RAMP_TICK_NS = 1000;
  localparam int RAMP_DIV     = RAMP_TICK_NS / CLK_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    CMD_NONE, CMD_HOME_SEARCH, CMD_HOME_NO_SEARCH, CMD_REL, CMD_ABS, CMD_VAR, CMD_PULSE
  } ppa_cmd_t;

  typedef struct packed {
    logic near;
    logic zero;
    logic fwd_lim;
    logic bwd_lim;
    logic enable;
  } ppa_sens_t;

  typedef struct packed {
    logic signed [31:0] target;
    logic [31:0]        run_speed;
    logic [31:0]        home_speed;
    logic [31:0]        creep_speed;
    logic [31:0]        ramp_step;
  } ppa_cfg_t;

  localparam ppa_cfg_t CFG_RST = '{
    target:      32'sh0000_0000,
    run_speed:   32'h0010_0000,
    home_speed:  32'h0010_0000,
    creep_speed: 32'h0001_0000,
    ramp_step:   32'h0000_1000
  };

endpackage

// ### ppa_ramp.sv
// Purpose: Speed ramp, moves the output rate toward a target rate in steps
// Assumes: One step per ramp tick; step of zero means jump at once
// Notes:   Hold forces the rate to zero immediately
`timescale 1ns/100ps
`default_nettype none
module ppa_ramp #(
  parameter int TICK_DIV = ppa_pkg::RAMP_DIV
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] target,
  input  wire logic [31:0] step,
  input  wire logic        hold,
  output logic      [31:0] rate
);

  if (TICK_DIV < 1 || TICK_DIV > 65536) begin : g_chk
    $error("ppa_ramp: TICK_DIV out of range");
  end

  typedef struct packed {
    logic [15:0] div;
    logic [31:0] rate;
  } ppa_ramp_st_t;

  ppa_ramp_st_t q;
  ppa_ramp_st_t d;

  always_comb begin
    d = q;
    d.div = (q.div == 16'(TICK_DIV - 1)) ? 16'h0000 : q.div + 16'h0001;
    if (hold) begin
      d.rate = 32'h0000_0000;
    end else if (step == 32'h0000_0000) begin
      d.rate = target;
    end else if (q.div == 16'(TICK_DIV - 1)) begin
      // Ramp rather than jump on every speed change
      if (q.rate < target) begin
        d.rate = (target - q.rate > step) ? q.rate + step : target;
      end else if (q.rate > target) begin
        d.rate = (q.rate - target > step) ? q.rate - step : target;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rate = q.rate;

endmodule
`default_nettype wire

// ### ppa_pulse_gen.sv
// Purpose: Phase-accumulator pulse generator
// Assumes: Rate below 2**31, so at most one pulse per clock
// Notes:   Pulse is the accumulator MSB, about 50 % duty; step marks its rise
`timescale 1ns/100ps
`default_nettype none
module ppa_pulse_gen (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] rate,
  input  wire logic        run,
  output logic             pulse,
  output logic             step
);

  typedef struct packed {
    logic [31:0] acc;
    logic        step;
  } ppa_pg_st_t;

  ppa_pg_st_t q;
  ppa_pg_st_t d;

  // Runs by itself once started, no software pacing
  always_comb begin
    d.acc  = run ? q.acc + rate : 32'h0000_0000;
    d.step = !q.acc[31] && d.acc[31];
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pulse = q.acc[31];
  assign step  = q.step;

endmodule
`default_nettype wire

// ### ppa_axis.sv
// Purpose: Single-axis pulse/direction positioning controller with AXI4-Lite
// Assumes: Sensor pins are asynchronous and pass a two-stage synchroniser
// Notes:   Stops are abrupt; starts from zero and speed changes while running are ramped
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Searching home runs at homing speed and hunts the near-point sensor itself.
// - Near-point sensor going active during homing slows the axis to creep speed.
// - Searching home stops at zero-point input while creeping, then reports done.
// - Non-searching home stops when near-point sensor goes inactive, then done.
// - Near-point release at carriage trailing end stops pulses and means origin.
// - Relative move runs at set speed for commanded displacement from here.
// - Absolute move runs at set speed until position equals target.
// - Variable-speed run ramps to a changed speed instead of jumping.
// - Variable-speed run stops pulsing once command enable drops.
// - Position is signed 32-bit in pulse units.
// - Position counts up or down with each pulse by direction, except pulses of the plain pulse command.
// - Retained drive position is loaded as current coordinate before moving.
// - Plain pulse command drives pulses only, leaving direction alone.
// - Direction output is high for forward travel, low for reverse.
// - First valid command owns the output; later ones are refused meanwhile.
// - Pulse generation runs independently once a command has started.
module ppa_axis #(
  parameter int RAMP_DIV = ppa_pkg::RAMP_DIV
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic [ppa_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ppa_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      near_point_sensor,
  input  wire logic                      zero_point,
  input  wire logic                      fwd_limit,
  input  wire logic                      bwd_limit,
  input  wire logic                      cmd_enable,
  output logic                           pulse_out,
  output logic                           dir_out,
  output logic                           busy,
  output logic                           done
);

  typedef enum logic [2:0] {S_IDLE, S_DIR, S_MOVE, S_VAR, S_HFAST, S_HCREEP} ppa_mst_t;

  typedef struct packed {
    ppa_pkg::ppa_sens_t         s1;
    ppa_pkg::ppa_sens_t         s2;
    logic                       near_p;
    logic                       zero_p;
    logic                       aw_v;
    logic [ppa_pkg::ADDR_W-1:0] aw_a;
    logic                       w_v;
    logic [31:0]                w_d;
    logic [3:0]                 w_s;
    logic                       b_v;
    logic [1:0]                 b_r;
    logic                       r_v;
    logic [1:0]                 r_r;
    logic [31:0]                r_d;
    ppa_pkg::ppa_cfg_t          cfg;
    logic signed [31:0]         pos;
    logic [31:0]                remain;
    logic                       pos_ok;
    logic                       done_st;
    logic                       ref_st;
    logic                       flt_st;
    logic                       dir;
    logic                       done;
    logic                       track;
    logic                       search;
    ppa_pkg::ppa_cmd_t          cmd;
    ppa_mst_t                   st;
    ppa_mst_t                   nxt;
  } ppa_main_t;

  ppa_main_t   q;
  ppa_main_t   n;
  logic [31:0] rate_tgt;
  logic [31:0] rate;
  logic        hold;
  logic        run;
  logic        step;

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // 33 bits so target minus position can never overflow
  function automatic logic [31:0] magn(input logic signed [32:0] v);
    logic signed [32:0] a;
    a = (v < 0) ? -v : v;
    return a[31:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic                 wr;
    logic                 start;
    ppa_pkg::ppa_cmd_t    code;
    ppa_pkg::ppa_sens_t   sn;
    logic                 stop;
    logic                 homed;
    logic                 lim;
    logic signed [32:0]   diff;
    logic [31:0]          status;
    wr     = q.aw_v && q.w_v && !q.b_v;
    start  = 1'b0;
    code   = ppa_pkg::CMD_NONE;
    sn     = q.s2;
    stop   = 1'b0;
    homed  = 1'b0;
    lim    = 1'b0;
    diff   = 33'sh0_0000_0000;
    status = 32'h0000_0000;
    n      = q;
    n.done = 1'b0;

    n.s1     = '{near: near_point_sensor, zero: zero_point, fwd_lim: fwd_limit,
                 bwd_lim: bwd_limit, enable: cmd_enable};
    n.s2     = q.s1;
    n.near_p = sn.near;
    n.zero_p = sn.zero;

    status[ppa_pkg::ST_BUSY]    = q.st != S_IDLE;
    status[ppa_pkg::ST_DONE]    = q.done_st;
    status[ppa_pkg::ST_REFUSED] = q.ref_st;
    status[ppa_pkg::ST_FAULT]   = q.flt_st;
    status[ppa_pkg::ST_POS_OK]  = q.pos_ok;
    status[ppa_pkg::ST_DIR]     = q.dir;
    status[ppa_pkg::ST_NEAR]    = sn.near;
    status[ppa_pkg::ST_ZERO]    = sn.zero;
    status[ppa_pkg::ST_FWD_LIM] = sn.fwd_lim;
    status[ppa_pkg::ST_BWD_LIM] = sn.bwd_lim;
    status[ppa_pkg::ST_ENABLE]  = sn.enable;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    if (s_axi_awvalid && !q.aw_v && !q.b_v) begin
      n.aw_v = 1'b1;
      n.aw_a = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_v && !q.b_v) begin
      n.w_v = 1'b1;
      n.w_d = s_axi_wdata;
      n.w_s = s_axi_wstrb;
    end
    if (q.b_v && s_axi_bready) begin
      n.b_v = 1'b0;
    end
    if (q.r_v && s_axi_rready) begin
      n.r_v = 1'b0;
    end
    if (wr) begin
      n.aw_v = 1'b0;
      n.w_v  = 1'b0;
      n.b_v  = 1'b1;
      n.b_r  = ppa_pkg::RESP_OKAY;
      case (q.aw_a)
        ppa_pkg::REG_CMD: begin
          start = q.w_s[0];
          code  = ppa_pkg::ppa_cmd_t'(q.w_d[2:0]);
        end
        ppa_pkg::REG_STATUS: begin
          n.done_st = q.done_st && !(q.w_s[0] && q.w_d[ppa_pkg::ST_DONE]);
          n.ref_st  = q.ref_st && !(q.w_s[0] && q.w_d[ppa_pkg::ST_REFUSED]);
          n.flt_st  = q.flt_st && !(q.w_s[0] && q.w_d[ppa_pkg::ST_FAULT]);
        end
        ppa_pkg::REG_TARGET:     n.cfg.target = merge(q.cfg.target, q.w_d, q.w_s);
        ppa_pkg::REG_RUN_SPEED:  n.cfg.run_speed = merge(q.cfg.run_speed, q.w_d, q.w_s);
        ppa_pkg::REG_HOME_SPEED: n.cfg.home_speed = merge(q.cfg.home_speed, q.w_d, q.w_s);
        ppa_pkg::REG_CREEP:      n.cfg.creep_speed = merge(q.cfg.creep_speed, q.w_d, q.w_s);
        ppa_pkg::REG_RAMP_STEP:  n.cfg.ramp_step = merge(q.cfg.ramp_step, q.w_d, q.w_s);
        ppa_pkg::REG_POSITION: begin
          // Load retained drive position; ignored while moving
          if (q.st == S_IDLE) begin
            n.pos    = merge(q.pos, q.w_d, q.w_s);
            n.pos_ok = 1'b1;
          end
        end
        default: n.b_r = ppa_pkg::RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && !q.r_v) begin
      n.r_v = 1'b1;
      n.r_r = ppa_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ppa_pkg::REG_CMD:        n.r_d = {29'h0000_0000, 3'(q.st == S_IDLE ? 3'h0 : q.cmd)};
        ppa_pkg::REG_STATUS:     n.r_d = status;
        ppa_pkg::REG_TARGET:     n.r_d = q.cfg.target;
        ppa_pkg::REG_RUN_SPEED:  n.r_d = q.cfg.run_speed;
        ppa_pkg::REG_HOME_SPEED: n.r_d = q.cfg.home_speed;
        ppa_pkg::REG_CREEP:      n.r_d = q.cfg.creep_speed;
        ppa_pkg::REG_RAMP_STEP:  n.r_d = q.cfg.ramp_step;
        ppa_pkg::REG_POSITION:   n.r_d = q.pos;
        default: begin
          n.r_d = 32'h0000_0000;
          n.r_r = ppa_pkg::RESP_SLVERR;
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Motion sequencer
    if (step && q.track) begin
      n.pos = q.dir ? q.pos + 32'sd1 : q.pos - 32'sd1;
    end
    if (start && q.st != S_IDLE) begin
      n.ref_st = 1'b1;
    end
    case (q.st)
      S_IDLE: begin
        if (start && code != ppa_pkg::CMD_NONE) begin
          if (!sn.enable || code > ppa_pkg::CMD_PULSE
              || (code == ppa_pkg::CMD_ABS && !q.pos_ok)) begin
            n.ref_st = 1'b1;
          end else begin
            n.cmd    = code;
            n.st     = S_DIR;
            n.track  = code != ppa_pkg::CMD_PULSE;
            n.search = code == ppa_pkg::CMD_HOME_SEARCH;
            n.remain = 32'h0000_0000;
            case (code)
              ppa_pkg::CMD_REL: begin
                diff     = {q.cfg.target[31], q.cfg.target};
                n.dir    = !diff[32];
                n.remain = magn(diff);
                n.nxt    = S_MOVE;
              end
              ppa_pkg::CMD_ABS: begin
                diff     = {q.cfg.target[31], q.cfg.target} - {q.pos[31], q.pos};
                n.dir    = !diff[32];
                n.remain = magn(diff);
                n.nxt    = S_MOVE;
              end
              ppa_pkg::CMD_VAR: begin
                n.dir = !q.cfg.target[31];
                n.nxt = S_VAR;
              end
              ppa_pkg::CMD_PULSE: begin
                n.remain = q.cfg.target; // Direction left as it was
                n.nxt    = S_MOVE;
              end
              default: begin
                n.dir = 1'b0; // Homing heads backward
                n.nxt = S_HFAST;
              end
            endcase
          end
        end
      end
      S_DIR: begin
        // One idle clock with direction settled before pulsing
        if (q.nxt == S_MOVE && q.remain == 32'h0000_0000) begin
          stop = 1'b1;
        end else begin
          n.st = q.nxt;
        end
      end
      S_MOVE: begin
        if (step) begin
          n.remain = q.remain - 32'h0000_0001;
          stop     = q.remain == 32'h0000_0001;
        end
      end
      S_VAR: begin
        stop = !sn.enable;
      end
      S_HFAST: begin
        if (sn.near && !q.near_p) begin
          n.st = S_HCREEP;
        end
      end
      S_HCREEP: begin
        if (q.search) begin
          homed = sn.zero && !q.zero_p;
        end else begin
          homed = !sn.near && q.near_p;
        end
        stop = homed;
      end
      default: n.st = S_IDLE;
    endcase

    lim = q.dir ? sn.fwd_lim : sn.bwd_lim;
    if (lim && q.st inside {S_MOVE, S_VAR, S_HFAST, S_HCREEP} && !stop) begin
      if (q.st == S_HFAST && q.search && !q.dir) begin
        // Backward end reached without near-point: search forward instead
        n.dir = 1'b1;
        n.st  = S_DIR;
        n.nxt = S_HFAST;
      end else begin
        stop     = 1'b1;
        n.flt_st = 1'b1;
      end
    end
    if (homed) begin
      n.pos    = 32'sh0000_0000;
      n.pos_ok = 1'b1;
    end
    if (stop) begin
      n.st      = S_IDLE;
      n.done    = 1'b1;
      n.done_st = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q     <= '0;
      q.cfg <= ppa_pkg::CFG_RST;
    end else begin
      q <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Speed select and pulse path
  always_comb begin
    case (q.st)
      S_MOVE, S_VAR: rate_tgt = q.cfg.run_speed;
      S_HFAST:       rate_tgt = q.cfg.home_speed;
      S_HCREEP:      rate_tgt = q.cfg.creep_speed;
      default:       rate_tgt = 32'h0000_0000;
    endcase
  end

  assign hold = q.st == S_IDLE || q.st == S_DIR;
  assign run  = !hold;

  ppa_ramp #(
    .TICK_DIV (RAMP_DIV)
  ) u_ramp (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .target  (rate_tgt),
    .step    (q.cfg.ramp_step),
    .hold    (hold),
    .rate    (rate)
  );

  ppa_pulse_gen u_pulse (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .rate    (rate),
    .run     (run),
    .pulse   (pulse_out),
    .step    (step)
  );

  assign dir_out       = q.dir;
  assign busy          = q.st != S_IDLE;
  assign done          = q.done;
  assign s_axi_awready = !q.aw_v && !q.b_v;
  assign s_axi_wready  = !q.w_v && !q.b_v;
  assign s_axi_bvalid  = q.b_v;
  assign s_axi_bresp   = q.b_r;
  assign s_axi_arready = !q.r_v;
  assign s_axi_rvalid  = q.r_v;
  assign s_axi_rresp   = q.r_r;
  assign s_axi_rdata   = q.r_d;

endmodule
`default_nettype wire

// ### ppa_axis_asserts.sv
// Purpose: Port-level checks of bus handshakes and motion flags
// Assumes: One clock domain, rstn active low
// Notes:   Bound into every ppa_axis instance
`timescale 1ns/100ps
`default_nettype none
module ppa_axis_asserts (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pulse_out,
  input wire logic        dir_out,
  input wire logic        busy,
  input wire logic        done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  done_one_clk_a: assert property (done |=> !done) else $error("done too long");
  done_busy_a: assert property (done |-> !busy && $past(busy)) else $error("busy not cleared");
  pulse_busy_a: assert property ($rose(pulse_out) |-> busy) else $error("pulse while idle");
  dir_settle_a: assert property ($rose(pulse_out) |-> $stable(dir_out)) else $error("dir late");
  // Response must follow address and data accepted in the same clock by exactly two edges
  wr_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("no write response");
  rd_resp_a: assert property (ar_taken |=> s_axi_rvalid) else $error("no read response");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted under response");
endmodule
bind ppa_axis ppa_axis_asserts ppa_axis_asserts_i (.sys_clk, .rstn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pulse_out,
  .dir_out, .busy, .done);
`default_nettype wire

// ### ppa_drive_model.sv
// Purpose: Drive and carriage model with near, zero and limit sensors
// Assumes: One step per rising pulse, dir high is forward
// Notes:   gap is clocks between the last two pulses
`timescale 1ns/100ps
`default_nettype none
module ppa_drive_model #(
  parameter int NEAR_HI = -10,
  parameter int NEAR_LO = -30,
  parameter int ZERO_AT = -25,
  parameter int LIM     = 1000
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          pulse_out,
  input  wire logic          dir_out,
  output logic               near_point_sensor,
  output logic               zero_point,
  output logic               fwd_limit,
  output logic               bwd_limit,
  output logic signed [31:0] pos,
  output logic        [31:0] gap,
  output logic        [31:0] cnt
);
  logic        prev_q;
  logic [31:0] age_q;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
      pos    <= '0;
      gap    <= '0;
      cnt    <= '0;
      age_q  <= '0;
    end else begin
      prev_q <= pulse_out;
      age_q  <= age_q + 32'h1;
      if (pulse_out && !prev_q) begin
        pos   <= dir_out ? pos + 32'sh1 : pos - 32'sh1;
        cnt   <= cnt + 32'h1;
        gap   <= age_q;
        age_q <= 32'h1;
      end
    end
  end
  // Cam spans a band of travel; release at either end
  assign near_point_sensor = (pos <= NEAR_HI) && (pos >= NEAR_LO);
  assign zero_point        = (pos == ZERO_AT);
  assign fwd_limit         = (pos >= LIM);
  assign bwd_limit         = (pos <= -LIM);
endmodule
`default_nettype wire

// ### tb_pulse_positioning_axis.sv
// Purpose: Register-level test of moves, homing and speed runs
// Assumes: Drive model owns all sensor pins
// Notes:   Ramp tick shortened to two clocks
`timescale 1ns/100ps
`default_nettype none
`define CHK(v, e) begin n_checks++; if ((v) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, (v), (e)); end end
module tb_pulse_positioning_axis;
  logic sys_clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic near_point_sensor, zero_point, fwd_limit, bwd_limit, cmd_enable;
  logic pulse_out, dir_out, busy, done;
  logic        [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        [31:0] s_axi_wdata, s_axi_rdata, mgap, mcnt, c0;
  logic        [3:0]  s_axi_wstrb;
  logic        [1:0]  s_axi_bresp, s_axi_rresp;
  logic signed [31:0] mpos;
  int                 n_mismatch, n_checks;
  localparam logic [31:0] RV [5] = '{32'h0, 32'h0010_0000, 32'h0010_0000, 32'h0001_0000, 32'h1000};
  ppa_axis #(.RAMP_DIV(2)) ppa_axis_i (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .near_point_sensor, .zero_point, .fwd_limit,
    .bwd_limit, .cmd_enable, .pulse_out, .dir_out, .busy, .done);
  ppa_drive_model ppa_drive_model_i (.sys_clk, .rstn, .pulse_out, .dir_out, .near_point_sensor,
    .zero_point, .fwd_limit, .bwd_limit, .pos(mpos), .gap(mgap), .cnt(mcnt));
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int k;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (k == 100) begin n_mismatch++; give_verdict(); end
    `CHK(s_axi_bresp, er)
  endtask
  // Masked compare of a register read, response code included
  task chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
           input logic [1:0] er = 2'h0);
    int k;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (k == 100) begin n_mismatch++; give_verdict(); end
    `CHK(s_axi_rdata & m, e)
    `CHK(s_axi_rresp, er)
  endtask
  // n below zero waits for done, otherwise for the model's pulse count
  task waitc(input int n);
    int k;
    for (k = 0; k < 30000; k++) begin
      @(posedge sys_clk);
      if (n < 0 ? done === 1'b1 : mcnt >= n) break;
    end
    if (k == 30000) begin n_mismatch++; give_verdict(); end
  endtask
  task cmd(input logic [31:0] t, input logic [31:0] c);
    wr(ppa_pkg::REG_TARGET, t);
    wr(ppa_pkg::REG_CMD, c);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    cmd_enable  = 1'b1;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) chk(8'h08 + 8'(4 * i), RV[i]);
    chk(ppa_pkg::REG_POSITION, 32'h0);
    chk(ppa_pkg::REG_STATUS, 32'h0, 32'h1f);
    chk(8'h20, 32'h0, '1, ppa_pkg::RESP_SLVERR);
    wr(8'h24, 32'h1, ppa_pkg::RESP_SLVERR);
    wr(ppa_pkg::REG_CMD, 32'h4);
    chk(ppa_pkg::REG_STATUS, 32'h4, 32'h15);
    wr(ppa_pkg::REG_STATUS, 32'he);
    wr(ppa_pkg::REG_RUN_SPEED, 32'h1000_0000);
    wr(ppa_pkg::REG_HOME_SPEED, 32'h1000_0000);
    wr(ppa_pkg::REG_CREEP, 32'h0100_0000);
    wr(ppa_pkg::REG_RAMP_STEP, 32'h0);
    cmd(32'h5, 32'h3);
    waitc(-1);
    chk(ppa_pkg::REG_POSITION, 32'h5);
    `CHK(dir_out, 1'b1)
    `CHK(mgap, 32'd16)
    cmd(32'd20, 32'h3);
    wr(ppa_pkg::REG_CMD, 32'h1);
    chk(ppa_pkg::REG_STATUS, 32'h5, 32'h5);
    waitc(-1);
    chk(ppa_pkg::REG_POSITION, 32'd25);
    cmd(-32'sd3, 32'h3);
    waitc(-1);
    chk(ppa_pkg::REG_POSITION, 32'd22);
    `CHK(dir_out, 1'b0)
    wr(ppa_pkg::REG_POSITION, 32'd100);
    cmd(32'd90, 32'h4);
    waitc(-1);
    chk(ppa_pkg::REG_POSITION, 32'd90);
    wr(ppa_pkg::REG_POSITION, 32'h8000_0002);
    cmd(-32'sd2, 32'h3);
    waitc(-1);
    chk(ppa_pkg::REG_POSITION, 32'h8000_0000);
    cmd(32'h0, 32'h1);
    waitc(-1);
    chk(ppa_pkg::REG_POSITION, 32'h0);
    chk(ppa_pkg::REG_STATUS, 32'h10, 32'h11);
    `CHK(mpos, -32'sd25)
    `CHK(mgap, 32'd256)
    // Back off beyond the cam before homing without search
    cmd(32'd40, 32'h3);
    waitc(-1);
    cmd(32'h0, 32'h2);
    waitc(-1);
    chk(ppa_pkg::REG_POSITION, 32'h0);
    `CHK(mpos, -32'sd31)
    `CHK(mgap, 32'd256)
    cmd(32'h3, 32'h6);
    waitc(-1);
    `CHK(dir_out, 1'b0)
    `CHK(mpos, -32'sd34)
    wr(ppa_pkg::REG_RAMP_STEP, 32'h0040_0000);
    cmd(32'h1, 32'h5);
    c0 = mcnt;
    waitc(int'(c0) + 2);
    `CHK(mgap > 32'd16, 1'b1)
    waitc(int'(c0) + 14);
    `CHK(mgap, 32'd16)
    @(posedge sys_clk);
    cmd_enable <= 1'b0;
    waitc(-1);
    c0 = mcnt;
    repeat (50) @(posedge sys_clk);
    `CHK(mcnt, c0)
    `CHK(busy, 1'b0)
    give_verdict();
  end
endmodule
`default_nettype wire
